// ---- design/hsp_handler_port.v ----
`timescale 1ns/1ns
`default_nettype none
`include "hsp_port_map.vh"
module hsp_handler_port #(
	parameter ALERT_CYCLES = 100
) (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire [1:0] trig_source,
	input  wire       external_trigger_in_n,
	input  wire       key_lock_n,
	input  wire       power_glitch,
	input  wire       meas_idle,
	input  wire       analog_done,
	input  wire       result_valid,
	input  wire [3:0] result_class,
	input  wire       result_over_upper,
	input  wire       result_under_lower,
	input  wire       result_sec_reject,
	input  wire       result_overload,
	output reg        meas_start,
	output reg        keys_disabled,
	output reg        sort_class_1_n,
	output reg        sort_class_2_n,
	output reg        sort_class_3_n,
	output reg        sort_class_4_n,
	output reg        sort_class_5_n,
	output reg        sort_class_6_n,
	output reg        sort_class_7_n,
	output reg        sort_class_8_n,
	output reg        sort_class_9_n,
	output reg        aux_class_n,
	output reg        no_class_match_n,
	output reg        primary_over_upper_n,
	output reg        primary_under_lower_n,
	output reg        secondary_reject_n,
	output reg        measure_overload_fail_n,
	output reg        analog_done_out_n,
	output reg        cycle_done_out_n,
	output reg        trigger_wait_n,
	output reg        fault_alert_n
);
	localparam ST_IDLE   = 2'd0;
	localparam ST_WAIT   = 2'd1;
	localparam ST_ANALOG = 2'd2;
	localparam ST_MATH   = 2'd3;

	wire       trig_s;
	wire       lock_s;
	reg        trig_d_r;
	reg  [1:0] st_r;
	reg  [1:0] st_nxt;
	reg  [15:0] alert_cnt_r;
	reg        results_landed_r;
	wire       ext_mode = (trig_source == `HSP_TRIG_EXTERNAL);
	wire       trig_rise = trig_s & ~trig_d_r;

	// both pins idle high, so the synchronisers reset high
	hsp_sync u_trig_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.din     (external_trigger_in_n),
		.dout    (trig_s)
	);
	hsp_sync u_lock_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.din     (key_lock_n),
		.dout    (lock_s)
	);

	function [10:0] class_lines_n;
		input [3:0] cls;
		integer i;
		begin
			class_lines_n = 11'h7ff;
			for (i = 1; i <= 10; i = i + 1)
				if (cls == i[3:0])
					class_lines_n[i-1] = 1'b0;
			if (cls == `HSP_CLASS_NONE || cls > `HSP_CLASS_AUX)
				class_lines_n[10] = 1'b0;
		end
	endfunction

	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:   if (meas_idle) st_nxt = ext_mode ? ST_WAIT : ST_ANALOG;
			ST_WAIT:   if (!ext_mode) st_nxt = ST_IDLE;
			           else if (trig_rise) st_nxt = ST_ANALOG;
			ST_ANALOG: if (analog_done) st_nxt = ST_MATH;
			ST_MATH:   if (result_valid) st_nxt = ST_IDLE;
			default:   st_nxt = ST_IDLE;
		endcase
	end

	// edge register idles high like the pin
	always @(posedge ref_clk) begin
		if (rst) begin
			trig_d_r <= 1'b1;
		end else begin
			trig_d_r <= trig_s;
		end
	end

	// wait state is only entered in external mode
	always @(posedge ref_clk) begin
		if (rst) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			meas_start <= 1'b0;
		end else begin
			// edge only counts in external mode
			meas_start <= (st_r == ST_WAIT && ext_mode && trig_rise) ||
				(st_r == ST_IDLE && meas_idle && !ext_mode);
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			keys_disabled <= 1'b0;
		end else begin
			keys_disabled <= ~lock_s;
		end
	end

	// built from the next state so the line matches st_r
	always @(posedge ref_clk) begin
		if (rst) begin
			trigger_wait_n <= 1'b1;
		end else begin
			// wait line tracks state; never in internal mode
			trigger_wait_n <= ~(st_nxt == ST_WAIT && ext_mode &&
				trig_source != `HSP_TRIG_INTERNAL);
		end
	end

	// class lines, held until next result
	always @(posedge ref_clk) begin
		if (rst) begin
			{no_class_match_n, aux_class_n, sort_class_9_n, sort_class_8_n,
			 sort_class_7_n, sort_class_6_n, sort_class_5_n,
			 sort_class_4_n, sort_class_3_n, sort_class_2_n,
			 sort_class_1_n} <= 11'h7ff;
		end else if (st_r == ST_MATH && result_valid) begin
			{no_class_match_n, aux_class_n, sort_class_9_n, sort_class_8_n,
			 sort_class_7_n, sort_class_6_n, sort_class_5_n,
			 sort_class_4_n, sort_class_3_n, sort_class_2_n,
			 sort_class_1_n} <= class_lines_n(result_class);
		end
	end

	// flags update only at end of math phase
	always @(posedge ref_clk) begin
		if (rst) begin
			primary_over_upper_n    <= 1'b1;
			primary_under_lower_n   <= 1'b1;
			secondary_reject_n      <= 1'b1;
			measure_overload_fail_n <= 1'b1;
		end else if (st_r == ST_MATH && result_valid) begin
			primary_over_upper_n    <= ~result_over_upper;
			primary_under_lower_n   <= ~result_under_lower;
			secondary_reject_n      <= ~result_sec_reject;
			measure_overload_fail_n <= ~result_overload;
		end
	end

	// results reach the lines one cycle ahead of cycle-done
	always @(posedge ref_clk) begin
		if (rst) begin
			results_landed_r <= 1'b0;
		end else begin
			results_landed_r <= (st_r == ST_MATH && result_valid);
		end
	end

	// a completion in the same cycle as the meas_start clear wins
	always @(posedge ref_clk) begin
		if (rst) begin
			analog_done_out_n <= 1'b1;
			cycle_done_out_n  <= 1'b1;
		end else begin
			if (st_r == ST_ANALOG && analog_done)
				analog_done_out_n <= 1'b0;
			else if (meas_start)
				analog_done_out_n <= 1'b1;
			if (results_landed_r)
				cycle_done_out_n <= 1'b0;
			else if (meas_start)
				cycle_done_out_n <= 1'b1;
		end
	end

	// alert on reset or power glitch
	always @(posedge ref_clk) begin
		if (rst) begin
			fault_alert_n <= 1'b0;
			alert_cnt_r   <= ALERT_CYCLES[15:0];
		end else if (power_glitch) begin
			fault_alert_n <= 1'b0;
			alert_cnt_r   <= ALERT_CYCLES[15:0];
		end else if (alert_cnt_r != 16'h0000) begin
			alert_cnt_r <= alert_cnt_r - 16'h0001;
		end else begin
			fault_alert_n <= 1'b1;
		end
	end
endmodule // hsp_handler_port
`default_nettype wire

// ---- design/hsp_port_map.vh ----
// How it works
// - slash-named pins are driven active low
// - one class, aux or no-match line asserted
// - trigger on rising edge of external pulse
// - external trigger honoured only in external mode
// - over-upper flag when primary exceeds upper limit
// - under-lower flag when primary below lower limit
// - secondary reject when secondary outside limits
// - trigger-wait asserted only while awaiting trigger
// - internal trigger keeps trigger-wait deasserted
// - overload flag when analog measurement overloads
// - lockout input disables every front panel key
// - alert on power glitch or port reset
// - analog-done once analog phase completes
// - cycle-done only once all results valid
`ifndef HSP_PORT_MAP_VH
`define HSP_PORT_MAP_VH
`define HSP_TRIG_INTERNAL   2'h0
`define HSP_TRIG_EXTERNAL   2'h1
`define HSP_TRIG_MANUAL     2'h2
`define HSP_TRIG_BUS        2'h3
`define HSP_CLK_MHZ         100
`define HSP_TRIG_MIN_NS     1000
`define HSP_ALERT_CYCLES    16'h0064
`define HSP_CLASS_NONE      4'h0
`define HSP_CLASS_AUX       4'ha
`endif

// ---- design/hsp_sync.v ----
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module hsp_sync (
	input  wire ref_clk,
	input  wire rst,
	input  wire din,
	output reg  dout
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	always @(posedge ref_clk) begin
		if (rst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			dout <= 1'b1;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				dout <= s3_r;
		end
	end
endmodule // hsp_sync
`default_nettype wire

// ---- test/hsp_handler_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hsp_handler_model (
	input  wire logic ref_clk,
	input  wire logic fire,
	output var logic  external_trigger_in_n
);
	initial external_trigger_in_n = 1'b1;
	always @(posedge fire) begin
		@(negedge ref_clk) external_trigger_in_n = 1'b0;
		repeat (100) @(negedge ref_clk);
		external_trigger_in_n = 1'b1;
	end
endmodule // hsp_handler_model
`default_nettype wire

// ---- test/hsp_handler_port_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module hsp_chk (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       meas_start,
	input wire logic       power_glitch,
	input wire logic       analog_done,
	input wire logic       result_valid,
	input wire logic       result_over_upper,
	input wire logic       result_under_lower,
	input wire logic       result_sec_reject,
	input wire logic       result_overload,
	input wire logic       analog_done_out_n,
	input wire logic       cycle_done_out_n,
	input wire logic       trigger_wait_n,
	input wire logic       fault_alert_n,
	input wire logic       primary_over_upper_n,
	input wire logic       primary_under_lower_n,
	input wire logic       secondary_reject_n,
	input wire logic       measure_overload_fail_n,
	input wire logic [1:0] trig_source
);
	wire [3:0] fl = {primary_over_upper_n, primary_under_lower_n, secondary_reject_n,
		measure_overload_fail_n};
	wire [3:0] rf = {result_over_upper, result_under_lower, result_sec_reject, result_overload};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_int; trig_source == 2'h0 && $past(trig_source) == 2'h0
		&& $past(trig_source, 2) == 2'h0 |-> trigger_wait_n; endproperty
	a_int: assert property (p_int) else $error("wait shown in internal mode");
	property p_cdone; $fell(cycle_done_out_n) |-> $past(result_valid, 2); endproperty
	a_cdone: assert property (p_cdone) else $error("cycle done off walk");
	property p_hold; !cycle_done_out_n && !$past(cycle_done_out_n) |-> $stable(fl); endproperty
	a_hold: assert property (p_hold) else $error("flags moved");
	property p_flags; $fell(cycle_done_out_n) |-> fl == ~$past(rf, 2); endproperty
	a_flags: assert property (p_flags) else $error("flag mismatch");
	property p_adone; $fell(analog_done_out_n) |-> $past(analog_done); endproperty
	a_adone: assert property (p_adone) else $error("analog done early");
	property p_alert; $rose(power_glitch) |-> ##[1:8] !fault_alert_n; endproperty
	a_alert: assert property (p_alert) else $error("no alert");
	property p_start; meas_start |-> ##[1:2] trigger_wait_n; endproperty
	a_start: assert property (p_start) else $error("still waiting");
	property p_clear; meas_start |=> cycle_done_out_n [*2]; endproperty
	a_clear: assert property (p_clear) else $error("stale cycle done");
	c_cyc: cover property ($fell(cycle_done_out_n));
	c_adone: cover property ($fell(analog_done_out_n));
	c_alert: cover property ($fell(fault_alert_n));
endmodule // hsp_chk
bind hsp_handler_port hsp_chk u_chk (.*);
`default_nettype wire

// ---- test/hsp_handler_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hsp_port_map.vh"
module hsp_handler_port_tb;
	logic ref_clk, rst, key_lock_n, power_glitch, meas_idle, analog_done, result_valid, fire;
	logic result_over_upper, result_under_lower, result_sec_reject, result_overload;
	logic [1:0] trig_source;
	logic [3:0] result_class;
	logic meas_start, keys_disabled, analog_done_out_n, cycle_done_out_n, trigger_wait_n;
	logic fault_alert_n;
	wire external_trigger_in_n, sort_class_1_n, sort_class_2_n, sort_class_3_n, sort_class_4_n;
	wire sort_class_5_n, sort_class_6_n, sort_class_7_n, sort_class_8_n, sort_class_9_n;
	wire aux_class_n, no_class_match_n, primary_over_upper_n, primary_under_lower_n;
	wire secondary_reject_n, measure_overload_fail_n;
	wire [10:0] cls = ~{no_class_match_n, aux_class_n, sort_class_9_n, sort_class_8_n,
		sort_class_7_n, sort_class_6_n, sort_class_5_n, sort_class_4_n, sort_class_3_n,
		sort_class_2_n, sort_class_1_n};
	wire [3:0] fl = ~{primary_over_upper_n, primary_under_lower_n, secondary_reject_n,
		measure_overload_fail_n};
	int error_cnt = 0;
	int check_count = 0;
	hsp_handler_port #(.ALERT_CYCLES(4)) dut (.*);
	hsp_handler_model hm (.*);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
			error_cnt++;
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	localparam int sel_wait = 0, sel_start = 1, sel_adone = 2;
	localparam int sel_cdone = 3, sel_keys = 4, sel_alert = 5;
	function automatic logic pick(input int k);
		case (k)
			sel_wait:  return trigger_wait_n;
			sel_start: return meas_start;
			sel_adone: return analog_done_out_n;
			sel_cdone: return cycle_done_out_n;
			sel_keys:  return keys_disabled;
			default:   return fault_alert_n;
		endcase
	endfunction
	task automatic wt(input int k, input logic v);
		for (int n = 0; n < 400 && pick(k) !== v; n++) @(negedge ref_clk);
		chk(pick(k), v);
		if (pick(k) !== v) end_of_test();
	endtask
	task automatic t_cycle(input logic [3:0] c, f);
		meas_idle = 1'b1;
		wt(sel_wait, 1'b0);
		fire = 1'b1;
		wt(sel_start, 1'b1);
		@(negedge ref_clk);
		{fire, meas_idle, analog_done} = 3'h1;
		wt(sel_adone, 1'b0);
		chk(cycle_done_out_n, 1'b1);
		// next part may go in once analog is done
		analog_done = 1'b0;
		{result_valid, result_class} = {1'b1, c};
		{result_over_upper, result_under_lower, result_sec_reject, result_overload} = f;
		@(negedge ref_clk);
		result_valid = 1'b0;
		wt(sel_cdone, 1'b0);
		chk(cls, (c > 4'h0 && c < 4'ha) ? 11'h1 << (c - 4'h1) : 11'h200 << (c != 4'ha));
		chk(fl, f);
	endtask
	task automatic t_mode;
		meas_idle = 1'b1;
		wt(sel_wait, 1'b0);
		{trig_source, meas_idle, fire} = {`HSP_TRIG_BUS, 2'h1};
		wt(sel_wait, 1'b1);
		repeat (150) @(negedge ref_clk) chk(meas_start, 1'b0);
		{trig_source, meas_idle, fire} = {`HSP_TRIG_INTERNAL, 2'h2};
		wt(sel_start, 1'b1);
		@(negedge ref_clk);
		analog_done = 1'b1;
		wt(sel_adone, 1'b0);
		{analog_done, result_valid, result_class} = {2'h1, 4'h5};
		@(negedge ref_clk);
		result_valid = 1'b0;
		wt(sel_cdone, 1'b0);
		chk(cls, 11'h010);
		repeat (20) @(negedge ref_clk) chk(trigger_wait_n, 1'b1);
		meas_idle = 1'b0;
	endtask
	task automatic t_lock;
		key_lock_n = 1'b0;
		wt(sel_keys, 1'b1);
		{key_lock_n, power_glitch} = 2'h3;
		@(negedge ref_clk);
		power_glitch = 1'b0;
		wt(sel_alert, 1'b0);
		wt(sel_keys, 1'b0);
		wt(sel_alert, 1'b1);
	endtask
	initial begin
		{rst, key_lock_n, power_glitch, meas_idle, analog_done, result_valid, fire} = 7'h60;
		{result_over_upper, result_under_lower, result_sec_reject, result_overload} = 4'h0;
		{trig_source, result_class} = {`HSP_TRIG_EXTERNAL, 4'h0};
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		chk(fault_alert_n, 1'b0);
		chk(cls, 11'h0);
		for (int i = 0; i < 12; i++) t_cycle(i[3:0], i[3:0]);
		t_mode();
		t_lock();
		end_of_test();
	end
endmodule // hsp_handler_port_tb
`default_nettype wire
